// ===== logic/gopm_top.sv
// Eight-bit general output port with routable motion-complete signal
`include "gopm_defines.svh"
// How it works
// - Eight ports form one read/write word; routed ports read back the routed signal.
// - Single-bit write turns a chosen port on (1) or off (0); write only.
// - Direct writes to a port carrying a routed signal are ignored.
// - Write-only selector 0..7 routes the motion-complete signal onto one port.
// - With inversion set, the routed port carries the complement of the signal.
// - Routing is volatile and returns to factory default at power-up reset.
// - Starting a program, by command or start input, restores routing defaults.
// - Clearing alarms, by command or clear input, restores routing defaults.
module gopm_top
  import gopm_pkg::*;
(
  input  wire logic        SYS_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        HSEL_I,
  input  wire logic [11:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic        MOTION_DONE_I,
  input  wire logic        PROGRAM_START_I,
  input  wire logic        ALARM_CLEAR_INPUT_I,
  output logic      [7:0]  PORT_O
);
  import gopm_pkg::*;

  // ********************************
  // Bus address phase
  // ********************************
  gopm_ahb_req_t req_d;
  gopm_ahb_req_t req_q;
  logic          wr_act;
  logic          rd_act;

  assign req_d = '{sel: HSEL_I, addr: HADDR_I, write: HWRITE_I, size: HSIZE_I,
                   trans: HTRANS_I};

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      req_q <= '0;
    end else if (HREADY_I) begin
      req_q <= req_d;
      req_q.sel <= HSEL_I && HTRANS_I[1];
    end
  end

  assign wr_act = req_q.sel && req_q.write;
  assign rd_act = HSEL_I && HTRANS_I[1] && !HWRITE_I && HREADY_I;

  // ********************************
  // Routing state
  // ********************************
  gopm_route_t route_q;
  logic        restore;
  logic        ctrl_wr;

  assign ctrl_wr = wr_act && (req_q.addr == `GOPM_OFF_CONTROL);
  assign restore = PROGRAM_START_I || ALARM_CLEAR_INPUT_I ||
                   (ctrl_wr && (HWDATA_I[`GOPM_CTRL_RUN_POS] ||
                                HWDATA_I[`GOPM_CTRL_ALARM_CLEAR_POS] ||
                                HWDATA_I[`GOPM_CTRL_RESTORE_POS]));

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      route_q <= '{en: `GOPM_DONE_EN_RST, port: `GOPM_DONE_SEL_RST,
                   inv: `GOPM_DONE_INV_RST};
    end else if (restore) begin
      route_q <= '{en: `GOPM_DONE_EN_RST, port: `GOPM_DONE_SEL_RST,
                   inv: `GOPM_DONE_INV_RST};
    end else if (wr_act && req_q.addr == `GOPM_OFF_DONE_SEL) begin
      route_q.port <= HWDATA_I[2:0];
      route_q.en   <= HWDATA_I[`GOPM_DONE_SEL_EN_POS];
    end else if (wr_act && req_q.addr == `GOPM_OFF_DONE_INV) begin
      route_q.inv <= HWDATA_I[0];
    end
  end

  // ********************************
  // Direct port latch
  // ********************************
  logic [7:0] routed_mask;
  logic [7:0] direct_q;
  logic [7:0] port_d;
  logic       done_level;
  logic [2:0] bit_num;

  localparam logic [7:0] port_rst = `GOPM_PORT_RST;

  assign done_level = MOTION_DONE_I ^ route_q.inv;
  assign bit_num    = HWDATA_I[`GOPM_PORT_BIT_NUM_LSB +: 3];

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_port
      assign routed_mask[g] = route_q.en && (route_q.port == 3'(g));

      always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          direct_q[g] <= port_rst[g];
        end else if (!routed_mask[g]) begin
          if (wr_act && req_q.addr == `GOPM_OFF_PORT_WORD) begin
            direct_q[g] <= HWDATA_I[g];
          end else if (wr_act && req_q.addr == `GOPM_OFF_PORT_BIT && bit_num == 3'(g)) begin
            direct_q[g] <= HWDATA_I[`GOPM_PORT_BIT_VAL_POS];
          end
        end
      end

      assign port_d[g] = routed_mask[g] ? done_level : direct_q[g];
    end
  endgenerate

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      PORT_O <= `GOPM_PORT_RST;
    end else begin
      PORT_O <= port_d;
    end
  end

  // ********************************
  // Read data and response
  // ********************************
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      HRDATA_O <= 32'h0000_0000;
    end else if (rd_act) begin
      unique case (HADDR_I)
        `GOPM_OFF_PORT_WORD: HRDATA_O <= {24'h00_0000, port_d};
        `GOPM_OFF_STATUS:    HRDATA_O <= {27'h000_0000, route_q.inv, route_q.en,
                                          route_q.port};
        default:             HRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
    end
  end
endmodule

// ===== logic/gopm_defines.svh
// Register offsets, field positions and reset values of the output port mapper
`ifndef GOPM_DEFINES_SVH
`define GOPM_DEFINES_SVH

`define GOPM_OFF_PORT_WORD    12'h000
`define GOPM_OFF_PORT_BIT     12'h004
`define GOPM_OFF_DONE_SEL     12'h008
`define GOPM_OFF_DONE_INV     12'h00c
`define GOPM_OFF_CONTROL      12'h010
`define GOPM_OFF_STATUS       12'h014

`define GOPM_PORT_BIT_NUM_LSB 0
`define GOPM_PORT_BIT_VAL_POS 8
`define GOPM_DONE_SEL_EN_POS  3
`define GOPM_CTRL_RUN_POS     0
`define GOPM_CTRL_ALARM_CLEAR_POS 1
`define GOPM_CTRL_RESTORE_POS 2

`define GOPM_PORT_RST         8'h00
`define GOPM_DONE_EN_RST      1'b0
`define GOPM_DONE_SEL_RST     3'h0
`define GOPM_DONE_INV_RST     1'b0

`endif

// ===== logic/gopm_pkg.sv
// Types shared by the output port mapper
package gopm_pkg;
  typedef struct packed {
    logic        sel;
    logic [11:0] addr;
    logic        write;
    logic [2:0]  size;
    logic [1:0]  trans;
  } gopm_ahb_req_t;

  typedef struct packed {
    logic       en;
    logic [2:0] port;
    logic       inv;
  } gopm_route_t;
endpackage

// ===== sim/gopm_equip.sv
// Equipment wired to the output pins
module gopm_equip (
  input  wire logic       clk_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] load_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i) load_o <= pin_i;
endmodule

// ===== sim/gopm_top_asserts.sv
// Assertions on the output port mapper
module gopm_top_asserts (
  input wire logic        SYS_CLK_I, RST_I, HSEL_I, HWRITE_I, HREADY_I,
  input wire logic        MOTION_DONE_I, PROGRAM_START_I, ALARM_CLEAR_INPUT_I,
  input wire logic [11:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic        HREADYOUT_O, HRESP_O,
  input wire logic [7:0]  PORT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  logic        w_q, r_q, i_q;
  logic [11:0] a_q;
  logic [2:0]  p_q;
  logic [7:0]  m;
  wire cw = w_q & a_q == 12'h010 & |HWDATA_I[2:0];
  assign m = {7'h00, r_q} << p_q;
  always_ff @(posedge SYS_CLK_I) begin
    w_q <= !RST_I & HSEL_I & HTRANS_I[1] & HREADY_I & HWRITE_I;
    a_q <= HADDR_I;
  end
  always_ff @(posedge SYS_CLK_I)
    if (RST_I | PROGRAM_START_I | ALARM_CLEAR_INPUT_I | cw) {r_q, p_q, i_q} <= 5'h00;
    else if (w_q & a_q == 12'h008) {r_q, p_q} <= HWDATA_I[3:0];
    else if (w_q & a_q == 12'h00c) i_q <= HWDATA_I[0];
  property p_rst; $fell(RST_I) |-> PORT_O == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_rte; r_q |=> PORT_O[$past(p_q)] == $past(MOTION_DONE_I ^ i_q); endproperty
  a_rte: assert property (p_rte) else $error("route");
  property p_inv; r_q & i_q |=> PORT_O[$past(p_q)] != $past(MOTION_DONE_I); endproperty
  a_inv: assert property (p_inv) else $error("invert");
  property p_wrd; w_q & a_q == 12'h000 |-> ##2
    ((PORT_O ^ $past(HWDATA_I[7:0], 2)) & ~$past(m, 2)) == 8'h00; endproperty
  a_wrd: assert property (p_wrd) else $error("word");
  property p_bit; w_q & a_q == 12'h004 & !m[HWDATA_I[2:0]] |-> ##2
    PORT_O[$past(HWDATA_I[2:0], 2)] == $past(HWDATA_I[8], 2); endproperty
  a_bit: assert property (p_bit) else $error("bit");
  sequence s_start; PROGRAM_START_I ##1 !w_q; endsequence
  sequence s_aclr; ALARM_CLEAR_INPUT_I ##1 !w_q; endsequence
  sequence s_cmd; cw ##1 !w_q; endsequence
  sequence s_quiet; ##1 $stable(PORT_O); endsequence
  property p_run; s_start |=> s_quiet; endproperty
  a_run: assert property (p_run) else $error("start");
  property p_acl; s_aclr |=> s_quiet; endproperty
  a_acl: assert property (p_acl) else $error("clear");
  property p_cmd; s_cmd |=> s_quiet; endproperty
  a_cmd: assert property (p_cmd) else $error("command");
  property p_okay; HREADYOUT_O && !HRESP_O; endproperty
  a_okay: assert property (p_okay) else $error("bus response");
endmodule
bind gopm_top gopm_top_asserts u_chk (.*);

// ===== sim/test_general_output_port_mapper.sv
// Bench of the output port mapper
module test_general_output_port_mapper;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, sel = 0, wr = 0, dn = 1, st = 0, ac = 0, rdy;
  logic [1:0] tr = 0;
  logic [11:0] ad = 0;
  logic [31:0] wd = 0, rdat, rd;
  logic [7:0] port, load;
  logic resp;
  int err_count, n_tests, cyc;
  logic [31:0] rows[8] = '{32'h000_05a_5a, 32'h004_107_da, 32'h004_001_d8, 32'h008_009_da,
    32'h00c_001_d8, 32'h000_0ff_fd, 32'h004_101_fd, 32'h010_004_fd};
  gopm_top dut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(sel), .HADDR_I(ad), .HTRANS_I(tr),
    .HWRITE_I(wr), .HSIZE_I(3'h2), .HWDATA_I(wd), .HREADY_I(rdy), .HRDATA_O(rdat),
    .HREADYOUT_O(rdy), .HRESP_O(resp), .MOTION_DONE_I(dn), .PROGRAM_START_I(st),
    .ALARM_CLEAR_INPUT_I(ac), .PORT_O(port));
  gopm_equip eq (.clk_i(clk), .pin_i(port), .load_o(load));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) if (++cyc > 3000) begin err_count++; give_verdict(); end
  task automatic chk(string s, logic [31:0] x, y);
    n_tests++;
    if (x !== y) begin err_count++; $display("mismatch %s expected %h seen %h", s, x, y); end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    {sel, tr, ad, wr} <= {3'h6, a, w};
    do @(posedge clk); while (rdy !== 1'b1);
    {tr, wd} <= {2'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    rd = rdat;
  endtask
  task automatic give_verdict;
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    foreach (rows[i]) begin
      bus(1, rows[i][31:20], rows[i][19:8]);
      repeat (3) @(posedge clk);
      #1 chk("row", rows[i][7:0], load);
    end
    bus(1, 12'h000, 0);
    for (int p = 0; p < 8; p++) begin
      dn <= p[0];
      bus(1, 12'h008, 8 | p);
      bus(0, 12'h000, 0);
      chk("read", (p & 1) << p, rd);
      chk("resp", 0, resp);
    end
    for (int k = 0; k < 4; k++) begin
      bus(1, 12'h008, 12'hd);
      bus(1, 12'h00c, 1);
      bus(0, 12'h014, 0);
      chk("route", 32'h0000_001d, rd);
      if (k < 2) begin {ac, st} <= 2'h1 << k; @(posedge clk); {ac, st} <= 2'h0; end
      else bus(1, 12'h010, 1 << (k - 2));
      @(posedge clk);
      dn <= ~dn;
      bus(0, 12'h014, 0);
      chk("status", 0, rd);
    end
    bus(0, 12'h018, 0);
    chk("unmapped", 0, rd);
    bus(1, 12'h008, 12'hd);
    bus(1, 12'h000, 12'hff);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    #1 chk("reset", 0, port);
    bus(0, 12'h014, 0);
    chk("route after reset", 0, rd);
    chk("resp", 0, resp);
    give_verdict();
  end
endmodule
